// ---- include/spm_pkg.sv ----
`default_nettype none
package spm_pkg;
	// register offsets on the control port
	localparam logic [11:0] ADDR_CTRL    = 12'h270;
	localparam logic [11:0] ADDR_PER_LO  = 12'h271;
	localparam logic [11:0] ADDR_PER_MID = 12'h272;
	localparam logic [11:0] ADDR_PER_HI  = 12'h273;
	localparam logic [11:0] ADDR_UPD     = 12'h274;
	localparam logic [11:0] ADDR_RES_LO  = 12'h275;
	localparam logic [11:0] ADDR_RES_MID = 12'h276;
	localparam logic [11:0] ADDR_RES_HI  = 12'h277;
	localparam logic [11:0] ADDR_FCNT    = 12'h278;
	localparam logic [11:0] ADDR_LEA     = 12'h279;
	localparam logic [11:0] ADDR_LEB     = 12'h27a;
	localparam logic [11:0] ADDR_CBA     = 12'h559;
	localparam logic [11:0] ADDR_CBB     = 12'h55a;
	localparam logic [11:0] ADDR_CBC     = 12'h58f;
	// field positions
	localparam int CTRL_PEAK_EN_BIT = 1;
	localparam int UPD_REQ_BIT      = 4;
	localparam int LEB_MON_BIT      = 1;
	localparam int CBA_PRBS_BIT     = 2;
	localparam int CBC_INS_BIT      = 0;
	localparam logic [1:0] LEA_MON_BITS = 2'h3;
	// widths and counts
	localparam int PEAK_W  = 13;
	localparam int PER_W   = 24;
	localparam int CONV_W  = 14;
	localparam int WORD_W  = 16;
	localparam int RES_W   = 20;
	localparam int PAD_W   = RES_W - PEAK_W;
	localparam int FRAME_W = 25;
	localparam int LFSR_W  = 15;
	localparam logic [4:0] FRAME_BITS = 5'h19;
	localparam logic [PER_W-1:0] TIMER_LAST = 24'h000001;
	localparam logic [PEAK_W-1:0] PEAK_MAX = 13'h1fff;
	// reset values
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 15'h7fff;

	typedef enum logic [1:0] {
		SPM_IDLE = 2'b00,
		SPM_SEED = 2'b01,
		SPM_RUN  = 2'b10
	} spm_mon_state_type;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} spm_req_type;

	typedef struct packed {
		logic [WORD_W-1:0] word;
		logic              valid;
	} spm_link_type;

	typedef struct packed {
		logic [7:0]       ctrl;
		logic [PER_W-1:0] period;
		logic [7:0]       lea;
		logic [7:0]       leb;
		logic [7:0]       cba;
		logic [7:0]       cbb;
		logic [7:0]       cbc;
	} spm_regs_type;

	typedef struct packed {
		spm_regs_type           regs;
		spm_mon_state_type      mon;
		logic [PER_W-1:0]       timer;
		logic [PEAK_W-1:0]      run;
		logic [PEAK_W-1:0]      hold;
		logic [PEAK_W-1:0]      result;
		logic                   fresh;
		logic [7:0]             fcnt;
		logic                   pend;
		logic [PEAK_W-1:0]      pend_data;
		logic [1:0][PEAK_W-1:0] fifo;
		logic                   wptr;
		logic                   rptr;
		logic [1:0]             cnt;
		logic [FRAME_W-1:0]     ser;
		logic [4:0]             ser_cnt;
		logic [LFSR_W-1:0]      lfsr;
		logic [7:0]             rdata;
		spm_link_type           link;
	} spm_state_type;
endpackage
`default_nettype wire

// ---- logic/spm_signal_monitor.sv ----
// Summary of operation
// R1: 13-bit peak, 24-bit sample period
// R2: compare magnitudes only, sign ignored
// R3: control bit 1 enables peak detection
// R4: software writes period before enabling
// R5: load period, count down per sample
// R6: keep larger of input and running peak
// R7: seed running peak with current magnitude
// R8: timer at one copies peak to holding
// R9: reload timer, reseed, continue comparing
// R10: update request after a new peak refreshes counter and result
// R11: software polls counter until it changes
// R12: result is 20-bit word, MSB aligned
// R13: stream needs enable bits in both registers
// R14: up to three control bits, one monitor
// R15: control bits fill from MSB downward
// R16: 25-bit frame, five start-led subframes
// R17: software routes stream via link config
// R18: converter bits 13..6, then 5..0 plus tail
// R19: tail zero or pseudorandom, else control
// R20: disabled: timer idle, holding kept
`timescale 1ns/1ps
`default_nettype none
module spm_signal_monitor
	import spm_pkg::*;
(
	input  wire logic              clock,        // 100 MHz clock
	input  wire logic              resetn,       // async reset, active low
	input  wire logic              sample_valid, // decimated sample enable
	input  wire logic [CONV_W-1:0] sample,       // signed converter sample
	input  wire spm_req_type       reg_req,      // control port access
	output var  logic [7:0]        reg_rdata,    // read data, one cycle later
	output var  spm_link_type      link_out      // link sample word
);

	spm_state_type     s;
	spm_state_type     next_s;
	logic              peak_en;
	logic              ctrl_on;
	logic              stream_en;
	logic [1:0]        cs;
	logic [PEAK_W-1:0] cur_mag;
	logic [PEAK_W-1:0] pk;
	logic              latched;
	logic              upd_req;
	logic              push;
	logic              load;
	logic              mon_bit;
	logic [RES_W-1:0]  res_word;
	logic [1:0]        top;
	logic [1:0]        idx;
	logic [WORD_W-1:0] w;

	////////////////////////////////////////////////////////////////
	// helpers

	// saturate, since the most negative code has no 13-bit magnitude
	function automatic logic [PEAK_W-1:0] mag13(input logic [CONV_W-1:0] v);
		logic [CONV_W-1:0] a;
		a = v[CONV_W-1] ? (~v + 14'h0001) : v; // [R2]
		return (a > {1'b0, PEAK_MAX}) ? PEAK_MAX : a[PEAK_W-1:0];
	endfunction

	function automatic logic [PEAK_W-1:0] max13(input logic [PEAK_W-1:0] a,
		input logic [PEAK_W-1:0] b);
		return (a > b) ? a : b;
	endfunction

	function automatic logic [FRAME_W-1:0] frame25(input logic [PEAK_W-1:0] p);
		logic [RES_W-1:0] f;
		f = {p, {PAD_W{1'b0}}};
		return {1'b1, f[19:16], 1'b1, f[15:12], 1'b1, f[11:8],
			1'b1, f[7:4], 1'b1, f[3:0]}; // [R16]
	endfunction

	////////////////////////////////////////////////////////////////
	// decode

	assign peak_en   = s.regs.ctrl[CTRL_PEAK_EN_BIT]; // [R3]
	assign cs        = s.regs.cba[1:0];
	assign ctrl_on   = s.regs.cbc[CBC_INS_BIT] && (cs != 2'h0);
	assign stream_en = (s.regs.lea[1:0] == LEA_MON_BITS) && s.regs.leb[LEB_MON_BIT]
		&& ctrl_on; // [R13]
	assign cur_mag   = mag13(sample);
	assign pk        = max13(s.run, cur_mag); // [R6]
	assign upd_req   = reg_req.wr && (reg_req.addr == ADDR_UPD)
		&& reg_req.wdata[UPD_REQ_BIT];
	assign push      = s.pend && (s.cnt != 2'h2);
	assign load      = stream_en && sample_valid && (s.ser_cnt == 5'h00) && (s.cnt != 2'h0);
	assign mon_bit   = (s.ser_cnt != 5'h00) && s.ser[FRAME_W-1];
	assign res_word  = {s.result, {PAD_W{1'b0}}}; // [R12]
	assign top       = (cs == 2'h3) ? 2'h2 : 2'h1;

	assign reg_rdata = s.rdata;
	assign link_out  = s.link;

	////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_s  = s;
		latched = 1'b0;
		idx     = 2'h0;
		w       = '0;

		// peak detector
		case (s.mon)
			SPM_IDLE: begin
				if (peak_en) begin
					next_s.mon = SPM_SEED;
				end
			end
			SPM_SEED: begin
				if (!peak_en) begin
					next_s.mon = SPM_IDLE; // [R20]
				end else if (sample_valid) begin
					next_s.run = cur_mag; // [R7]
					if (s.regs.period <= TIMER_LAST) begin
						next_s.hold = cur_mag;
						latched     = 1'b1;
					end else begin
						next_s.timer = s.regs.period - TIMER_LAST; // [R5]
						next_s.mon   = SPM_RUN;
					end
				end
			end
			SPM_RUN: begin
				if (!peak_en) begin
					next_s.mon = SPM_IDLE; // [R20]
				end else if (sample_valid) begin
					if (s.timer == TIMER_LAST) begin
						next_s.hold = pk; // [R8]
						latched     = 1'b1;
						next_s.mon  = SPM_SEED; // [R9]
					end else begin
						next_s.run   = pk; // [R6]
						next_s.timer = s.timer - TIMER_LAST; // [R5]
					end
				end
			end
			default: begin
				next_s.mon = SPM_IDLE;
			end
		endcase

		// update handshake; a latch in the same cycle keeps fresh set
		if (upd_req && s.fresh) begin
			next_s.result = s.hold; // [R10]
			next_s.fcnt   = s.fcnt + 8'h01;
			next_s.fresh  = 1'b0;
		end
		if (latched) begin
			next_s.fresh = 1'b1;
		end

		// stream hand-off; a newer peak replaces a waiting one
		if (push) begin
			next_s.fifo[s.wptr] = s.pend_data;
			next_s.wptr         = ~s.wptr;
			next_s.pend         = 1'b0;
		end
		if (latched && stream_en) begin
			next_s.pend      = 1'b1;
			next_s.pend_data = next_s.hold;
		end
		next_s.cnt = s.cnt + {1'b0, push} - {1'b0, load};

		// serializer, one bit per link sample, msb first
		if (!stream_en) begin
			next_s.ser_cnt = 5'h00;
		end else if (sample_valid) begin
			if (s.ser_cnt != 5'h00) begin
				next_s.ser     = {s.ser[FRAME_W-2:0], 1'b0};
				next_s.ser_cnt = s.ser_cnt - 5'h01;
			end else if (load) begin
				next_s.ser     = frame25(s.fifo[s.rptr]); // [R16]
				next_s.ser_cnt = FRAME_BITS;
				next_s.rptr    = ~s.rptr;
			end
		end

		// link word: data msb first, tail, then control bits
		next_s.link.valid = sample_valid;
		if (sample_valid) begin
			next_s.lfsr = {s.lfsr[LFSR_W-2:0], s.lfsr[LFSR_W-1] ^ s.lfsr[LFSR_W-2]};
			w = {sample, 2'b00}; // [R18]
			if (s.regs.cba[CBA_PRBS_BIT]) begin
				w[1:0] = s.lfsr[1:0]; // [R19]
			end
			if (ctrl_on) begin
				for (int i = 0; i < 3; i++) begin
					if (i < int'(cs)) begin // [R14]
						idx    = top - 2'(i); // [R15]
						w[idx] = stream_en && (s.regs.cbb[1:0] == 2'(i)) && mon_bit; // [R19]
					end
				end
			end
			next_s.link.word = w;
		end

		// register writes
		if (reg_req.wr) begin
			case (reg_req.addr)
				ADDR_CTRL:    next_s.regs.ctrl = reg_req.wdata;
				ADDR_PER_LO:  next_s.regs.period[7:0] = reg_req.wdata; // [R1]
				ADDR_PER_MID: next_s.regs.period[15:8] = reg_req.wdata;
				ADDR_PER_HI:  next_s.regs.period[23:16] = reg_req.wdata;
				ADDR_LEA:     next_s.regs.lea = reg_req.wdata;
				ADDR_LEB:     next_s.regs.leb = reg_req.wdata;
				ADDR_CBA:     next_s.regs.cba = reg_req.wdata;
				ADDR_CBB:     next_s.regs.cbb = reg_req.wdata;
				ADDR_CBC:     next_s.regs.cbc = reg_req.wdata;
				default:      next_s.regs = s.regs;
			endcase
		end

		// register reads
		if (reg_req.rd) begin
			case (reg_req.addr)
				ADDR_CTRL:    next_s.rdata = s.regs.ctrl;
				ADDR_PER_LO:  next_s.rdata = s.regs.period[7:0];
				ADDR_PER_MID: next_s.rdata = s.regs.period[15:8];
				ADDR_PER_HI:  next_s.rdata = s.regs.period[23:16];
				ADDR_RES_LO:  next_s.rdata = res_word[7:0]; // [R12]
				ADDR_RES_MID: next_s.rdata = res_word[15:8];
				ADDR_RES_HI:  next_s.rdata = {4'h0, res_word[19:16]};
				ADDR_FCNT:    next_s.rdata = s.fcnt;
				ADDR_LEA:     next_s.rdata = s.regs.lea;
				ADDR_LEB:     next_s.rdata = s.regs.leb;
				ADDR_CBA:     next_s.rdata = s.regs.cba;
				ADDR_CBB:     next_s.rdata = s.regs.cbb;
				ADDR_CBC:     next_s.rdata = s.regs.cbc;
				default:      next_s.rdata = REG_RST;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s      <= '0;
			s.lfsr <= LFSR_SEED;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	sequence s_last_sample;
		peak_en && sample_valid && (s.mon == SPM_RUN) && (s.timer == TIMER_LAST);
	endsequence

	sequence s_mid_sample;
		peak_en && sample_valid && (s.mon == SPM_RUN) && (s.timer != TIMER_LAST);
	endsequence

	property p_idle_hold;
		!peak_en |=> $stable(s.hold) && (s.mon == SPM_IDLE);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("holding moved while disabled"); // [R20]

	property p_seed;
		(peak_en && sample_valid && (s.mon == SPM_SEED)) |=> (s.run == mag13($past(sample)));
	endproperty
	a_seed: assert property (p_seed) else $error("running peak not seeded"); // [R7]

	property p_keep_max;
		s_mid_sample |=> (s.run == max13($past(s.run), mag13($past(sample))));
	endproperty
	a_keep_max: assert property (p_keep_max) else $error("running peak not the larger"); // [R6]

	property p_countdown;
		s_mid_sample |=> (s.timer == $past(s.timer) - TIMER_LAST);
	endproperty
	a_countdown: assert property (p_countdown) else $error("timer did not step down"); // [R5]

	property p_transfer;
		s_last_sample |=> (s.hold == max13($past(s.run), mag13($past(sample))))
			&& (s.mon == SPM_SEED) && s.fresh;
	endproperty
	a_transfer: assert property (p_transfer) else $error("peak not transferred"); // [R8]

	property p_update;
		(upd_req && s.fresh) |=> (s.fcnt == $past(s.fcnt) + 8'h01)
			&& (s.result == $past(s.hold));
	endproperty
	a_update: assert property (p_update) else $error("update did not refresh result"); // [R10]

	property p_res_high;
		(reg_req.rd && (reg_req.addr == ADDR_RES_HI)) |=> (s.rdata == {4'h0, $past(s.result[12:9])});
	endproperty
	a_res_high: assert property (p_res_high) else $error("result high byte misplaced"); // [R12]

	property p_frame_load;
		load |=> (s.ser_cnt == FRAME_BITS) && s.ser[24] && s.ser[19] && s.ser[14]
			&& s.ser[9] && s.ser[4];
	endproperty
	a_frame_load: assert property (p_frame_load) else $error("frame lacks start bits"); // [R16]

	property p_stream_off;
		!stream_en |=> (s.ser_cnt == 5'h00);
	endproperty
	a_stream_off: assert property (p_stream_off) else $error("stream runs while disabled"); // [R13]

	property p_data_bits;
		sample_valid |=> (s.link.word[15:3] == $past(sample[13:1])) && s.link.valid;
	endproperty
	a_data_bits: assert property (p_data_bits) else $error("converter bits misplaced"); // [R18]

	property p_buffer;
		push |=> (s.fifo[$past(s.wptr)] == $past(s.pend_data)) && (s.cnt != 2'h0);
	endproperty
	a_buffer: assert property (p_buffer) else $error("buffer lost a word");

endmodule // spm_signal_monitor
`default_nettype wire

// ---- bench/spm_link_receiver.sv ----
`timescale 1ns/1ps
`default_nettype none
module spm_link_receiver
	import spm_pkg::*;
#(
	parameter int SLOT = 1 // word bit of the monitor slot
)(
	input  wire logic         clock,    // sample clock
	input  wire logic         resetn,   // async reset, active low
	input  wire spm_link_type link_in,  // link sample word
	output var  logic [7:0]   frames,   // frames received
	output var  logic [12:0]  peak,     // last peak received
	output var  logic         start_err // a start bit was missing
);
	logic [23:0] shift;
	logic [4:0]  count;
	logic [24:0] frame;

	assign frame = {shift, link_in.word[SLOT]};

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			shift <= '0;
			count <= '0;
			frames <= '0;
			peak <= '0;
			start_err <= 1'b0;
		end else if (link_in.valid) begin
			shift <= frame[23:0];
			// idle slot is zero, so a one can only open a frame
			if (count == 5'h00) begin
				count <= {4'h0, frame[0]};
			end else if (count == 5'h18) begin
				count <= 5'h00;
				frames <= frames + 8'h01;
				peak <= {frame[23:20], frame[18:15], frame[13:10], frame[8]};
				if (!(frame[24] && frame[19] && frame[14] && frame[9] && frame[4])) begin
					start_err <= 1'b1;
				end
			end else begin
				count <= count + 5'h01;
			end
		end
	end
endmodule // spm_link_receiver
`default_nettype wire

// ---- bench/signal_peak_monitor_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module signal_peak_monitor_tb
	import spm_pkg::*;
;
	logic         clock;
	logic         resetn;
	logic         sample_valid;
	logic [13:0]  sample;
	spm_req_type  reg_req;
	logic [7:0]   reg_rdata;
	spm_link_type link_out;
	logic [7:0]   frames;
	logic [12:0]  peak;
	logic         start_err;
	int           err_count;
	int           comparisons;
	int           cycles;

	spm_signal_monitor u_dut (
		.clock(clock), .resetn(resetn), .sample_valid(sample_valid), .sample(sample),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .link_out(link_out));
	spm_link_receiver u_rx (
		.clock(clock), .resetn(resetn), .link_in(link_out),
		.frames(frames), .peak(peak), .start_err(start_err));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////
	task final_report();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task check(input logic [23:0] seen, input logic [23:0] expected);
		comparisons++;
		if (seen !== expected) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
		end
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		#1 reg_req.wr = 1'b0;
	endtask

	task rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clock);
		#1 reg_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		#1 reg_req.rd = 1'b0;
		d = reg_rdata;
	endtask

	task smp(input logic [13:0] v);
		@(posedge clock);
		#1 sample_valid = 1'b1;
		sample = v;
		@(posedge clock);
		#1 sample_valid = 1'b0;
	endtask

	// software side: request, poll the counter, then read the result
	task fetch(input logic [7:0] fc, input logic [19:0] res);
		logic [7:0] d;
		logic [7:0] lo;
		logic [7:0] mid;
		int n;
		n = 0;
		do begin
			wr(ADDR_UPD, 8'h10);
			rd(ADDR_FCNT, d);
			n++;
		end while (d !== fc && n < 4);
		check(d, fc);
		rd(ADDR_RES_LO, lo);
		rd(ADDR_RES_MID, mid);
		rd(ADDR_RES_HI, d);
		check({d, mid, lo}, {4'h0, res});
	endtask

	////////////////////////////////////////////////////////////////
	task t_reset();
		logic [7:0] d;
		rd(ADDR_CTRL, d);
		check(d, 8'h00);
		wr(ADDR_RES_LO, 8'hff);
		rd(ADDR_RES_LO, d);
		check(d, 8'h00);
		rd(12'h3ff, d);
		check(d, 8'h00);
		$display("test reset done");
	endtask

	task t_window();
		wr(ADDR_PER_LO, 8'h03);
		wr(ADDR_CTRL, 8'h02);
		smp(14'h3ffb);
		smp(14'h0007);
		smp(14'h0002);
		fetch(8'h01, {13'h0007, 7'h00});
		smp(14'h2000);
		smp(14'h0001);
		smp(14'h0001);
		fetch(8'h02, {13'h1fff, 7'h00});
		smp(14'h0001);
		smp(14'h0002);
		smp(14'h0001);
		fetch(8'h03, {13'h0002, 7'h00});
		$display("test window done");
	endtask

	task t_disable();
		wr(ADDR_CTRL, 8'h00);
		repeat (4) smp(14'h0100);
		fetch(8'h03, {13'h0002, 7'h00});
		$display("test disable done");
	endtask

	task t_link();
		wr(ADDR_LEA, 8'h03);
		wr(ADDR_CBA, 8'h01);
		wr(ADDR_CBB, 8'h00);
		wr(ADDR_CBC, 8'h01);
		wr(ADDR_PER_LO, 8'h02);
		wr(ADDR_CTRL, 8'h02);
		for (int i = 0; i < 30; i++) begin
			smp(14'h0064);
			check(link_out.word[1], 1'b0);
		end
		wr(ADDR_LEB, 8'h02);
		for (int i = 0; i < 80; i++) begin
			smp(14'h0064);
			check(link_out.word[15:2], 14'h0064);
			check(link_out.word[0], 1'b0);
			check(link_out.valid, 1'b1);
		end
		check(frames > 8'h01, 1'b1);
		check(peak, 13'h0064);
		check(start_err, 1'b0);
		$display("test link done");
	endtask

	task t_tail();
		logic seen_one;
		logic seen_zero;
		seen_one = 1'b0;
		seen_zero = 1'b0;
		wr(ADDR_CBA, 8'h05);
		// runs of a maximal 15-bit sequence are short, so both levels show
		for (int i = 0; i < 32; i++) begin
			smp(14'h0064);
			seen_one = seen_one | link_out.word[0];
			seen_zero = seen_zero | !link_out.word[0];
			check(link_out.word[15:2], 14'h0064);
		end
		check({seen_one, seen_zero}, 2'h3);
		// three control bits: monitor moved to the lowest slot
		wr(ADDR_CBA, 8'h03);
		wr(ADDR_CBB, 8'h02);
		seen_one = 1'b0;
		for (int i = 0; i < 40; i++) begin
			smp(14'h0064);
			seen_one = seen_one | link_out.word[0];
			check(link_out.word[15:3], 13'h0032);
			check(link_out.word[2:1], 2'h0);
		end
		check(seen_one, 1'b1);
		$display("test tail done");
	endtask

	////////////////////////////////////////////////////////////////
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end

	initial begin
		err_count = 0;
		comparisons = 0;
		cycles = 0;
		resetn = 1'b0;
		sample_valid = 1'b0;
		sample = 14'h0000;
		reg_req = '0;
		repeat (12) @(posedge clock);
		#1 resetn = 1'b1;
		t_reset();
		t_window();
		t_disable();
		t_link();
		t_tail();
		final_report();
	end
endmodule // signal_peak_monitor_tb
`default_nettype wire
